/* shared/pin_mux_consts.vh */
// constants for the remappable pin select multiplexer
// assumes the includer uses them as field widths, counts, indices and output codes
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

`define IN_SEL_W        8
`define OUT_SEL_W       7
`define SRC_SPACE       256
`define CODE_SPACE      128
`define N_IN_FUNC       37
`define N_PHYS          48
`define N_VIRT          6
`define N_PINS          54
`define WR_IDX_W        6
`define IN_SEL_RST      8'h00
`define OUT_SEL_RST     7'h00

// input index map
`define IDX_VSS         8'h00
`define IDX_COMPARATOR1_RESULT        8'h01
`define IDX_GEN4_HIGH   8'h05
`define IDX_SEQ30       8'h06
`define IDX_REF_OUT     8'h0C
`define IDX_SYNC1       8'h0D
`define IDX_GEN4_LOW    8'h0F
`define SLOT_G1_END     8'h05
`define SLOT_G2_END     8'h0F
`define SLOT_G3_END     8'h1F
`define SLOT_G4_END     8'h30
`define RP_G1_BASE      8'h10
`define RP_G2_BASE      8'h20
`define RP_G3_BASE      8'h2B
`define RP_G4_BASE      8'h3C
`define RP_VIRT_BASE    8'hB0

// output codes
`define OC_NULL         7'h00
`define OC_UART1_TX     7'h01
`define OC_UART2_RTS    7'h04
`define OC_SPI1_DATA    7'h05
`define OC_SPI2_SEL     7'h0A
`define OC_CAN1_TX      7'h0E
`define OC_CAN2_TX      7'h0F
`define OC_CMPOUT1      7'h10
`define OC_CMPOUT4      7'h13
`define OC_ACMP1        7'h18
`define OC_ACMP3        7'h1A
`define OC_SPI3_DATA    7'h1F
`define OC_SPI3_SEL     7'h21
`define OC_SYNC1        7'h2D
`define OC_SYNC2        7'h2E
`define OC_REFCLK       7'h31
`define OC_COMPARATOR4_OUTPUT        7'h32
`define OC_GEN4_HIGH    7'h33
`define OC_GEN5_LOW     7'h36
`define OC_GEN6_HIGH    7'h39
`define OC_GEN8_LOW     7'h3E
`define OC_CELL1        7'h3F
`define OC_CELL2        7'h40
`define OC_CELL3        7'h41
`define OC_CELL4        7'h42

`endif

/* verilog/remappable_pin_select_mux.v */
// remappable pin select multiplexer: input selection per peripheral input,
// output selection per remappable pin, six internal virtual pins.
// assumes peripherals and internal sources run on clk_i; package pins are asynchronous.
`include "pin_mux_consts.vh"

// Notes on behaviour
// - separate mapping tables for peripheral inputs and for pin outputs
// - every peripheral input has its own 8-bit source index
// - index 0 low, 1-15 internal sources, pin indices per map
// - indices 176-181 are virtual pins looping outputs back to inputs
// - one field each for the listed interrupt, timer, capture, fault, serial, sync, cell inputs
// - every pin has its own 7-bit output code field
// - output codes reset to zero, the null output
// - codes 1-4 route uart transmit and request-to-send
// - spi data, clock, select codes for three spi units
// - codes 0x0e, 0x0f route the can transmitters
// - codes 0x10-0x13 route output compare 1-4
// - codes 0x18-0x1a comparators 1-3, 0x32 comparator 4
// - sync outputs 0x2d, 0x2e and reference clock 0x31
// - pwm generator high/low outputs on 0x33-0x36 and 0x39-0x3e
// - logic cells on 0x3f-0x42, cells 3 and 4 variant only
// - no interlock: any mapping combination accepted; writes to an index past the last field are dropped
// - remapped function beats digital port functions, never analog ones
// - enabled dedicated output beats any remapped output
// - active remapped output overrides direction; remapped input does not
module remappable_pin_select_mux #(
  parameter HAS_CELL34 = 1
) (
  input  wire                      clk_i,
  input  wire                      rst_n_i,
  // configuration write and readback
  input  wire                      map_wr_en_i,
  input  wire                      map_wr_output_i,
  input  wire [`WR_IDX_W-1:0]      map_wr_idx_i,
  input  wire [`IN_SEL_W-1:0]      map_wr_data_i,
  input  wire                      map_rd_output_i,
  input  wire [`WR_IDX_W-1:0]      map_rd_idx_i,
  output reg  [`IN_SEL_W-1:0]      map_rd_data_o,
  // internal sources selectable as peripheral inputs
  input  wire [3:0]                comparator_result_i,
  input  wire                      pwm_gen4_high_out_i,
  input  wire                      pwm_gen4_low_out_i,
  input  wire [1:0]                sequencer_output_i,
  input  wire                      reference_output_i,
  input  wire [1:0]                pwm_sync_out_i,
  // peripheral outputs, bit k is the function with output code k
  input  wire [`CODE_SPACE-1:0]    periph_out_i,
  // peripheral inputs, one bit per input selection field
  output reg  [`N_IN_FUNC-1:0]     periph_in_o,
  // physical remappable pins
  input  wire [`N_PHYS-1:0]        remap_pin_in_i,
  output reg  [`N_PHYS-1:0]        remap_pin_out_o,
  output reg  [`N_PHYS-1:0]        remap_pin_oe_o,
  output reg  [`N_PHYS-1:0]        remap_active_o,
  // pin context from the port and dedicated functions
  input  wire [`N_PHYS-1:0]        analog_enable_i,
  input  wire [`N_PHYS-1:0]        dedicated_oe_i,
  input  wire [`N_PHYS-1:0]        dedicated_out_i,
  input  wire [`N_PHYS-1:0]        port_latch_i,
  input  wire [`N_PHYS-1:0]        pin_direction_bits_i
);

  reg  [`IN_SEL_W-1:0]  in_sel_r  [0:`N_IN_FUNC-1];
  reg  [`OUT_SEL_W-1:0] out_sel_r [0:`N_PINS-1];
  reg  [`N_PHYS-1:0]    pin_meta_r;
  reg  [`N_PHYS-1:0]    pin_sync_r;
  reg  [`SRC_SPACE-1:0] src;
  reg  [`N_PINS-1:0]    sel_val;
  reg  [`N_PINS-1:0]    sel_act;
  reg  [`N_IN_FUNC-1:0] periph_in_nxt;
  reg  [`N_PHYS-1:0]    pin_out_nxt;
  reg  [`N_PHYS-1:0]    pin_oe_nxt;
  // one loop index per process, so no variable has two drivers
  integer               i;
  integer               i_rd;
  integer               i_sel;
  integer               i_src;
  integer               i_in;
  integer               i_pin;

  // slot 0..53 to remap index; slots 48..53 are the virtual pins
  function [`IN_SEL_W-1:0] rp_of_slot;
    input integer s;
    begin
      if (s < `SLOT_G1_END)
        rp_of_slot = `RP_G1_BASE + s[7:0];
      else if (s < `SLOT_G2_END)
        rp_of_slot = `RP_G2_BASE + s[7:0] - `SLOT_G1_END;
      else if (s < `SLOT_G3_END)
        rp_of_slot = `RP_G3_BASE + s[7:0] - `SLOT_G2_END;
      else if (s < `SLOT_G4_END)
        rp_of_slot = `RP_G4_BASE + s[7:0] - `SLOT_G3_END;
      else
        rp_of_slot = `RP_VIRT_BASE + s[7:0] - `SLOT_G4_END;
    end
  endfunction

  // true for every output code that names a function
  function code_ok;
    input [`OUT_SEL_W-1:0] c;
    begin
      if (c >= `OC_UART1_TX && c <= `OC_UART2_RTS)
        code_ok = 1'b1;
      else if ((c >= `OC_SPI1_DATA && c <= `OC_SPI2_SEL) ||
               (c >= `OC_SPI3_DATA && c <= `OC_SPI3_SEL))
        code_ok = 1'b1;
      else if (c == `OC_CAN1_TX || c == `OC_CAN2_TX)
        code_ok = 1'b1;
      else if (c >= `OC_CMPOUT1 && c <= `OC_CMPOUT4)
        code_ok = 1'b1;
      else if ((c >= `OC_ACMP1 && c <= `OC_ACMP3) || c == `OC_COMPARATOR4_OUTPUT)
        code_ok = 1'b1;
      else if (c == `OC_SYNC1 || c == `OC_SYNC2 || c == `OC_REFCLK)
        code_ok = 1'b1;
      else if ((c >= `OC_GEN4_HIGH && c <= `OC_GEN5_LOW) ||
               (c >= `OC_GEN6_HIGH && c <= `OC_GEN8_LOW))
        code_ok = 1'b1;
      else if (c == `OC_CELL1 || c == `OC_CELL2)
        code_ok = 1'b1;
      else if (c == `OC_CELL3 || c == `OC_CELL4)
        code_ok = (HAS_CELL34 != 0);
      else
        code_ok = 1'b0;
    end
  endfunction

  // configuration storage; no cross-check between fields by design
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < `N_IN_FUNC; i = i + 1)
        in_sel_r[i] <= `IN_SEL_RST;
      for (i = 0; i < `N_PINS; i = i + 1)
        out_sel_r[i] <= `OUT_SEL_RST;
    end else if (map_wr_en_i) begin
      if (map_wr_output_i) begin
        if (map_wr_idx_i < `N_PINS)
          out_sel_r[map_wr_idx_i] <= map_wr_data_i[`OUT_SEL_W-1:0];
      end else begin
        if (map_wr_idx_i < `N_IN_FUNC)
          in_sel_r[map_wr_idx_i] <= map_wr_data_i;
      end
    end
  end

  // readback of the stored fields; out-of-range reads return zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      map_rd_data_o <= `IN_SEL_RST;
    else if (map_rd_output_i)
      map_rd_data_o <= (map_rd_idx_i < `N_PINS) ?
                       {1'b0, out_sel_r[map_rd_idx_i]} : `IN_SEL_RST;
    else
      map_rd_data_o <= (map_rd_idx_i < `N_IN_FUNC) ? in_sel_r[map_rd_idx_i] : `IN_SEL_RST;
  end

  // pins are asynchronous to clk_i
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= {`N_PHYS{1'b0}};
      pin_sync_r <= {`N_PHYS{1'b0}};
    end else begin
      pin_meta_r <= remap_pin_in_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  // selected peripheral output per slot; unassigned codes drive nothing
  always @* begin
    sel_val = {`N_PINS{1'b0}};
    sel_act = {`N_PINS{1'b0}};
    for (i_sel = 0; i_sel < `N_PINS; i_sel = i_sel + 1) begin
      sel_act[i_sel] = code_ok(out_sel_r[i_sel]);
      sel_val[i_sel] = sel_act[i_sel] & periph_out_i[out_sel_r[i_sel]];
    end
  end

  // source space seen by the input selectors; reserved indices stay low
  always @* begin
    src = {`SRC_SPACE{1'b0}};
    for (i_src = 0; i_src < 4; i_src = i_src + 1)
      src[`IDX_COMPARATOR1_RESULT + i_src] = comparator_result_i[i_src];
    src[`IDX_GEN4_HIGH] = pwm_gen4_high_out_i;
    src[`IDX_GEN4_LOW]  = pwm_gen4_low_out_i;
    src[`IDX_SEQ30]     = sequencer_output_i[0];
    src[`IDX_SEQ30 + 1] = sequencer_output_i[1];
    src[`IDX_REF_OUT]   = reference_output_i;
    src[`IDX_SYNC1]     = pwm_sync_out_i[0];
    src[`IDX_SYNC1 + 1] = pwm_sync_out_i[1];
    for (i_src = 0; i_src < `N_PHYS; i_src = i_src + 1)
      src[rp_of_slot(i_src)] = pin_sync_r[i_src];
    // virtual pins carry whatever output is mapped onto them
    for (i_src = `N_PHYS; i_src < `N_PINS; i_src = i_src + 1)
      src[rp_of_slot(i_src)] = sel_val[i_src];
    src[`IDX_VSS] = 1'b0;
  end

  always @* begin
    periph_in_nxt = {`N_IN_FUNC{1'b0}};
    for (i_in = 0; i_in < `N_IN_FUNC; i_in = i_in + 1)
      periph_in_nxt[i_in] = src[in_sel_r[i_in]];
  end

  // pin drive priority: dedicated output, remapped output unless analog, port
  always @* begin
    pin_out_nxt = {`N_PHYS{1'b0}};
    pin_oe_nxt  = {`N_PHYS{1'b0}};
    for (i_pin = 0; i_pin < `N_PHYS; i_pin = i_pin + 1) begin
      if (dedicated_oe_i[i_pin]) begin
        pin_out_nxt[i_pin] = dedicated_out_i[i_pin];
        pin_oe_nxt[i_pin]  = 1'b1;
      end else if (sel_act[i_pin] && !analog_enable_i[i_pin]) begin
        pin_out_nxt[i_pin] = sel_val[i_pin];
        pin_oe_nxt[i_pin]  = 1'b1;
      end else begin
        // remapped inputs leave direction to the port bits
        pin_out_nxt[i_pin] = port_latch_i[i_pin];
        pin_oe_nxt[i_pin]  = ~pin_direction_bits_i[i_pin];
      end
    end
  end

  // registered so every data output comes from a flop; costs one cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_in_o     <= {`N_IN_FUNC{1'b0}};
      remap_pin_out_o <= {`N_PHYS{1'b0}};
      remap_pin_oe_o  <= {`N_PHYS{1'b0}};
      remap_active_o  <= {`N_PHYS{1'b0}};
    end else begin
      periph_in_o     <= periph_in_nxt;
      remap_pin_out_o <= pin_out_nxt;
      remap_pin_oe_o  <= pin_oe_nxt;
      remap_active_o  <= sel_act[`N_PHYS-1:0] & ~analog_enable_i & ~dedicated_oe_i;
    end
  end

endmodule

/* bench/pin_mux_asserts.sv */
// checker: timing and priority relations seen at the pin mux ports
// assumes one clock domain; bound to the mux by the bind at the foot of this file
`include "pin_mux_consts.vh"
module pin_mux_asserts (
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   map_wr_en_i,
  input wire logic                   map_wr_output_i,
  input wire logic [`WR_IDX_W-1:0]   map_wr_idx_i,
  input wire logic [`IN_SEL_W-1:0]   map_wr_data_i,
  input wire logic                   map_rd_output_i,
  input wire logic [`WR_IDX_W-1:0]   map_rd_idx_i,
  input wire logic [`IN_SEL_W-1:0]   map_rd_data_o,
  input wire logic [`CODE_SPACE-1:0] periph_out_i,
  input wire logic [`N_IN_FUNC-1:0]  periph_in_o,
  input wire logic [`N_PHYS-1:0]     remap_pin_out_o,
  input wire logic [`N_PHYS-1:0]     remap_pin_oe_o,
  input wire logic [`N_PHYS-1:0]     remap_active_o,
  input wire logic [`N_PHYS-1:0]     analog_enable_i,
  input wire logic [`N_PHYS-1:0]     dedicated_oe_i,
  input wire logic [`N_PHYS-1:0]     dedicated_out_i,
  input wire logic [`N_PHYS-1:0]     port_latch_i,
  input wire logic [`N_PHYS-1:0]     pin_direction_bits_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire wr0  = map_wr_en_i && map_wr_output_i && map_wr_idx_i == 6'h00;
  // slot 0 left alone and free of analog or dedicated use for the cycle after the write
  wire free0 = !wr0 && !analog_enable_i[0] && !dedicated_oe_i[0];
  uart_route_a: assert property (
    wr0 && map_wr_data_i[6:0] == `OC_UART1_TX ##1 free0 |=> remap_active_o[0]
    && remap_pin_oe_o[0] && remap_pin_out_o[0] == $past(periph_out_i[1]))
    else $error("slot 0 does not carry code 1");
  null_code_a: assert property (
    wr0 && (map_wr_data_i[6:0] == 7'h00 || map_wr_data_i[6:0] == 7'h0B) ##1 free0
    |=> !remap_active_o[0]) else $error("null code took the pin");
  dedicated_wins_a: assert property (
    $past(rst_n_i) |-> (remap_pin_oe_o & $past(dedicated_oe_i)) == $past(dedicated_oe_i)
    && ((remap_pin_out_o ^ $past(dedicated_out_i)) & $past(dedicated_oe_i)) == '0)
    else $error("dedicated output lost the pin");
  analog_blocks_a: assert property (
    $past(rst_n_i) |-> (remap_active_o & $past(analog_enable_i)) == '0)
    else $error("remap active on analog pin");
  dir_override_a: assert property ((remap_active_o & ~remap_pin_oe_o) == '0)
    else $error("active remap not driving");
  port_fallback_a: assert property (
    $past(rst_n_i) |-> (~remap_active_o & ~$past(dedicated_oe_i) & ((remap_pin_oe_o
    ^ ~$past(pin_direction_bits_i)) | (remap_pin_oe_o & (remap_pin_out_o
    ^ $past(port_latch_i))))) == '0) else $error("port drive wrong");
  readback_a: assert property (
    map_wr_en_i && !map_wr_output_i && map_wr_idx_i < 6'h25 ##1 !map_rd_output_i
    && map_rd_idx_i == $past(map_wr_idx_i) |=> map_rd_data_o == $past(map_wr_data_i, 2))
    else $error("input field readback wrong");
  field_range_a: assert property (
    !map_rd_output_i && map_rd_idx_i > 6'h24 |=> map_rd_data_o == 8'h00)
    else $error("missing field reads nonzero");
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n_i ##1 !rst_n_i |-> remap_active_o == '0 && periph_in_o == '0
    && remap_pin_oe_o == '0) else $error("outputs not cleared in reset");
endmodule

bind remappable_pin_select_mux pin_mux_asserts chk (.*);

/* bench/periph_model.sv */
// far-side model: peripheral outputs, internal sources and package pin levels
// assumes the bench raises hold_i before it samples anything that depends on them
module periph_model (
  input  wire logic         clk_i,
  input  wire logic         hold_i,
  output logic [127:0]      periph_out_o,
  output logic [47:0]       pin_level_o,
  output wire logic [10:0]  src_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // mixed patterns shifted every cycle with the top bit inverted into the bottom while hold_i is low, so a stale or crossed selection shows up
  initial periph_out_o = {32{4'h6}};
  initial pin_level_o = {12{4'h9}};
  always @(posedge clk_i)
    if (!hold_i) begin
      periph_out_o <= {periph_out_o[126:0], ~periph_out_o[127]};
      pin_level_o  <= {pin_level_o[46:0], ~pin_level_o[47]};
    end
  assign src_o = pin_level_o[10:0] ^ 11'h2A5;
endmodule

/* bench/remappable_pin_select_mux_tb.sv */
// testbench: drives the mapping port, checks routing, priority and readback
// assumes the mux header on the include path and the far-side model beside it
`include "pin_mux_consts.vh"
module remappable_pin_select_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk_i = 1'b0, rst_n_i = 1'b0, hold = 1'b0;
  logic          map_wr_en_i = 1'b0, map_wr_output_i = 1'b0, map_rd_output_i = 1'b0;
  logic [5:0]    map_wr_idx_i = 6'h00, map_rd_idx_i = 6'h00;
  logic [7:0]    map_wr_data_i = 8'h00, map_rd_data_o;
  logic [127:0]  periph_out_i;
  logic [47:0]   remap_pin_in_i, remap_pin_out_o, remap_pin_oe_o, remap_active_o;
  logic [47:0]   analog_enable_i = 48'h0, dedicated_oe_i = 48'h0, dedicated_out_i = 48'h0;
  logic [47:0]   port_latch_i = {12{4'hC}}, pin_direction_bits_i = 48'h0;
  logic [36:0]   periph_in_o;
  wire  [10:0]   src;
  wire  [3:0]    comparator_result_i = src[3:0];
  wire           pwm_gen4_high_out_i = src[4];
  wire           pwm_gen4_low_out_i = src[5];
  wire  [1:0]    sequencer_output_i = src[7:6];
  wire           reference_output_i = src[8];
  wire  [1:0]    pwm_sync_out_i = src[10:9];
  int            error_cnt = 0, n_tests = 0;
  byte unsigned  codes[24] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0A, 8'h0E, 8'h0F,
    8'h10, 8'h13, 8'h18, 8'h1A, 8'h1F, 8'h21, 8'h2D, 8'h2E, 8'h31, 8'h32, 8'h33, 8'h36,
    8'h39, 8'h3E, 8'h41, 8'h42};
  int            fld[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 16, 15, 35};
  int            idx[14] = '{5, 8, 4, 16, 13, 76, 43, 20, 32, 12, 15, 175, 60, 176};

  always #50 clk_i = ~clk_i;
  remappable_pin_select_mux dut (.*);
  periph_model far (.clk_i(clk_i), .hold_i(hold), .periph_out_o(periph_out_i),
    .pin_level_o(remap_pin_in_i), .src_o(src));

  function automatic logic src_of(input int x);
    if (x >= 1 && x <= 4) return comparator_result_i[x-1];
    if (x == 5) return pwm_gen4_high_out_i;
    if (x == 6 || x == 7) return sequencer_output_i[x-6];
    if (x == 12) return reference_output_i;
    if (x == 13 || x == 14) return pwm_sync_out_i[x-13];
    if (x == 15) return pwm_gen4_low_out_i;
    if (x >= 16 && x <= 20) return remap_pin_in_i[x-16];
    if (x >= 32 && x <= 41) return remap_pin_in_i[x-27];
    if (x >= 43 && x <= 58) return remap_pin_in_i[x-28];
    if (x >= 60 && x <= 76) return remap_pin_in_i[x-29];
    // virtual slot 48 carries code 1 in this bench
    if (x == 176) return periph_out_i[1];
    return 1'b0;
  endfunction
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // strobe stays high across back-to-back writes; idle lowers it
  task automatic wr(input logic o, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk_i);
    map_wr_en_i <= 1'b1;
    map_wr_output_i <= o;
    map_wr_idx_i <= i;
    map_wr_data_i <= d;
  endtask
  task automatic idle(input int n);
    @(posedge clk_i);
    map_wr_en_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic o, input logic [5:0] i, input logic [7:0] e);
    @(posedge clk_i);
    map_rd_output_i <= o;
    map_rd_idx_i <= i;
    repeat (2) @(posedge clk_i);
    #1 chk("readback", {40'h0, e}, {40'h0, map_rd_data_o});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(1'b1, 6'h05, 8'h00);
    rd(1'b0, 6'h00, 8'h00);
    chk("active", 48'h0, remap_active_o);
    $display("test reset done");
    for (int i = 0; i < 24; i++) wr(1'b1, 6'(i), codes[i]);
    wr(1'b1, 6'h30, 8'h01);
    @(posedge clk_i);
    hold <= 1'b1;
    analog_enable_i <= 48'h4;
    dedicated_oe_i <= 48'h2;
    pin_direction_bits_i <= {48{1'b1}};
    idle(3);
    for (int i = 0; i < 24; i++)
      if (i > 2) chk("pin out", {47'h0, periph_out_i[codes[i]]}, {47'h0, remap_pin_out_o[i]});
    chk("pin drive", 48'hFF_FFFB, {24'h0, remap_pin_oe_o[23:0]});
    chk("dedicated", 48'h0, {47'h0, remap_pin_out_o[1]});
    chk("idle slot", 48'h0, {46'h0, remap_active_o[24], remap_pin_oe_o[24]});
    rd(1'b1, 6'h05, 8'h0A);
    $display("test outputs done");
    for (int k = 0; k < 14; k++) wr(1'b0, 6'(fld[k]), 8'(idx[k]));
    rd(1'b0, 6'h23, 8'hB0);
    wr(1'b0, 6'h28, 8'h05);
    idle(4);
    for (int k = 0; k < 14; k++) chk("periph in", {47'h0, src_of(idx[k])}, {47'h0, periph_in_o[fld[k]]});
    rd(1'b0, 6'h28, 8'h00);
    $display("test inputs done");
    analog_enable_i <= 48'h0;
    wr(1'b1, 6'h00, 8'h0B);
    idle(3);
    chk("unassigned", 48'h0, {47'h0, remap_active_o[0]});
    rst_n_i <= 1'b0;
    idle(3);
    chk("active", 48'h0, remap_active_o);
    rst_n_i <= 1'b1;
    rd(1'b1, 6'h03, 8'h00);
    rd(1'b0, 6'h23, 8'h00);
    $display("test second reset done");
    print_verdict();
  end
  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end
endmodule
